// ### design/svpb_regs.svh
// Constants of the extended vital product page: offsets, byte values and counts.
`ifndef SVPB_REGS_SVH
`define SVPB_REGS_SVH

//------------------------------------------------------------------------------
// Page selection and size
//------------------------------------------------------------------------------
`define SVPB_PAGE_CODE        8'hF0
`define SVPB_PAGE_BYTES       7'd100
`define SVPB_PAGE_LEN         8'd95
`define SVPB_DEV_TYPE         8'h06

//------------------------------------------------------------------------------
// Byte offsets
//------------------------------------------------------------------------------
`define SVPB_OFF_DEVTYPE      7'd0
`define SVPB_OFF_PAGE         7'd1
`define SVPB_OFF_JVER         7'd2
`define SVPB_OFF_LEN          7'd4
`define SVPB_OFF_BASIC_X      7'd5
`define SVPB_OFF_BASIC_Y      7'd7
`define SVPB_OFF_STEP         7'd9
`define SVPB_OFF_MAX_X        7'd10
`define SVPB_OFF_MAX_Y        7'd12
`define SVPB_OFF_MIN_X        7'd14
`define SVPB_OFF_MIN_Y        7'd16
`define SVPB_OFF_STD_RES      7'd18
`define SVPB_OFF_WIN_W        7'd20
`define SVPB_OFF_WIN_L        7'd24
`define SVPB_OFF_FUNC         7'd28
`define SVPB_OFF_PHYS         7'd32
`define SVPB_OFF_BUF          7'd34
`define SVPB_OFF_STD_CMD      7'd38
`define SVPB_OFF_VEND_CMD     7'd42
`define SVPB_OFF_VEND_PARM    7'd50
`define SVPB_OFF_IMG_CTL      7'd82
`define SVPB_OFF_IMG_PROC     7'd88
`define SVPB_OFF_COMPR        7'd90
`define SVPB_OFF_ENDORSE      7'd92

//------------------------------------------------------------------------------
// Field values
//------------------------------------------------------------------------------
`define SVPB_BASIC_RES        16'h00C8
`define SVPB_RES_STEP         8'h00
`define SVPB_MAX_RES          16'h0190
`define SVPB_MIN_RES_BASE     16'h00C8
`define SVPB_MIN_RES_IPO      16'h0032
`define SVPB_STD_RES_BASE     16'h01D0
`define SVPB_STD_RES_IPO      16'hFFF0
`define SVPB_WIN_W_WIDE       32'h00000980
`define SVPB_WIN_W_NARROW     32'h000006C0
`define SVPB_WIN_L            32'h00000D80
`define SVPB_FUNC             8'h06
`define SVPB_PHYS_HI_BASE     8'h92
`define SVPB_PHYS_HI_END      8'h9A
`define SVPB_PHYS_LO          8'h08
`define SVPB_BUF_SIZE         32'h00800000
`define SVPB_STD_CMD          32'h0000EDBF
`define SVPB_VGRP_C_BASE      16'h0000
`define SVPB_VGRP_C_END       16'h0002
`define SVPB_VGRP_ZERO        16'h0000
`define SVPB_VPARM_0X         16'h0001
`define SVPB_IMG_CTL_STEP     8'hFF
`define SVPB_IMG_CTL_DITHER   8'h48
`define SVPB_IMG_PROC_BASE    16'h8140
`define SVPB_IMG_PROC_IPO     16'hFF40
`define SVPB_COMPR            16'hE000
`define SVPB_ENDORSE_BASE     16'h0000
`define SVPB_ENDORSE_END      16'h8100

`endif

// ### design/svpb_pkg.sv
// Types shared by the vital product page builder.
`default_nettype none
package svpb_pkg;
	typedef enum logic [1:0] {
		SVPB_IDLE,
		SVPB_SEND,
		SVPB_DONE
	} svpb_state_t;
endpackage
`default_nettype wire

// ### design/svpb_page_builder.sv
// Vital product page builder: streams the 100-byte extended inquiry page.
//
// Operation
// - Page is sent only for an inquiry with vital data enable and code F0h.
// - Page is 100 bytes long; the page length byte reads 95.
// - Basic horizontal and vertical resolution both read 200 dpi.
// - The single resolution step byte reads 00h, continuously variable.
// - Maximum horizontal and vertical resolution read 400 regardless of option.
// - Minimum resolution reads 200 without image option, 50 with it.
// - Standard resolution bitmap reads 01D0h without option, FFF0h with it.
// - Bitmap first byte covers 60 to 200 ppi, second 240 to 1200.
// - Maximum window width 00000980h wide model, 000006C0h narrow model.
// - Maximum window length reads 00000D80h, in basic-resolution pixels.
// - Function byte reads 00000110b with the documented bit meanings.
// - Overflow bit stays clear since buffered data is never lost.
// - Physical byte 32 reads 92h or 9Ah with endorser; byte 33 converter bits.
// - Buffer size field reads 0080 0000h, eight megabytes.
// - Standard command bitmap reads 0000EDBFh.
// - Standard bitmap bits 0 to 25 map opcodes 00h to 5Ah; rest reserved.
// - Vendor command bytes 42 to 49 hold groups C, D, E and F.
// - Each group sends bits 15 to 8 first, then bits 7 to 0.
// - Group C reads 0002h with endorser, else 0000h; others read zero.
// - Vendor parameters at 50, image control 82, processing 88, compression 90, endorser 92.
`timescale 1ns/1ps
`default_nettype none
`include "svpb_regs.svh"

module svpb_page_builder
	import svpb_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	input  wire logic       inquiry_req,
	input  wire logic       vital_data_enable,
	input  wire logic [7:0] page_code,
	input  wire logic       endorser_fitted,
	input  wire logic       image_processing_option,
	input  wire logic       model_wide,
	input  wire logic       byte_ready,
	output var  logic       byte_valid_ff,
	output var  logic [7:0] byte_data_ff,
	output var  logic       byte_last_ff,
	output var  logic       page_busy_ff,
	output var  logic       page_refused_ff
);

	//--------------------------------------------------------------------------
	// Page content
	//--------------------------------------------------------------------------

	// Version code of the page format; the value is arbitrary.
	localparam logic [7:0] JVER_CODE = 8'h5A;

	// Picks one byte of a big-endian multi-byte field at a relative position.
	function automatic logic [7:0] field_byte(input logic [31:0] val,
	                                          input logic [1:0]  rel,
	                                          input logic [1:0]  len);
		logic [1:0] sh;
		sh = len - rel - 2'd1;
		field_byte = val[{sh, 3'b000} +: 8];
	endfunction

	// The whole page is a function of the byte index and the option straps.
	// Keeping it combinational over static inputs avoids a 100-byte store.
	function automatic logic [7:0] page_byte(input logic [6:0] idx,
	                                         input logic       endo,
	                                         input logic       ipo,
	                                         input logic       wide);
		logic [15:0] min_res;
		logic [15:0] std_res;
		logic [31:0] win_w;
		logic [15:0] grp_c;
		logic [15:0] proc;
		logic [15:0] endf;
		logic [6:0]  rel;
		min_res = ipo ? `SVPB_MIN_RES_IPO : `SVPB_MIN_RES_BASE;
		std_res = ipo ? `SVPB_STD_RES_IPO : `SVPB_STD_RES_BASE;
		win_w   = wide ? `SVPB_WIN_W_WIDE : `SVPB_WIN_W_NARROW;
		grp_c   = endo ? `SVPB_VGRP_C_END : `SVPB_VGRP_C_BASE;
		proc    = ipo ? `SVPB_IMG_PROC_IPO : `SVPB_IMG_PROC_BASE;
		endf    = endo ? `SVPB_ENDORSE_END : `SVPB_ENDORSE_BASE;
		rel     = 7'd0;
		page_byte = 8'h00;
		if (idx == `SVPB_OFF_DEVTYPE) begin
			page_byte = `SVPB_DEV_TYPE;
		end else if (idx == `SVPB_OFF_PAGE) begin
			page_byte = `SVPB_PAGE_CODE;
		end else if (idx == `SVPB_OFF_JVER) begin
			page_byte = JVER_CODE;
		end else if (idx == `SVPB_OFF_LEN) begin
			page_byte = `SVPB_PAGE_LEN;
		end else if (idx >= `SVPB_OFF_BASIC_X && idx < `SVPB_OFF_STEP) begin
			rel = idx - `SVPB_OFF_BASIC_X;
			page_byte = field_byte({16'h0000, `SVPB_BASIC_RES}, {1'b0, rel[0]}, 2'd2);
		end else if (idx == `SVPB_OFF_STEP) begin
			page_byte = `SVPB_RES_STEP;
		end else if (idx >= `SVPB_OFF_MAX_X && idx < `SVPB_OFF_MIN_X) begin
			rel = idx - `SVPB_OFF_MAX_X;
			page_byte = field_byte({16'h0000, `SVPB_MAX_RES}, {1'b0, rel[0]}, 2'd2);
		end else if (idx >= `SVPB_OFF_MIN_X && idx < `SVPB_OFF_STD_RES) begin
			rel = idx - `SVPB_OFF_MIN_X;
			page_byte = field_byte({16'h0000, min_res}, {1'b0, rel[0]}, 2'd2);
		end else if (idx >= `SVPB_OFF_STD_RES && idx < `SVPB_OFF_WIN_W) begin
			rel = idx - `SVPB_OFF_STD_RES;
			page_byte = field_byte({16'h0000, std_res}, {1'b0, rel[0]}, 2'd2);
		end else if (idx >= `SVPB_OFF_WIN_W && idx < `SVPB_OFF_WIN_L) begin
			rel = idx - `SVPB_OFF_WIN_W;
			page_byte = field_byte(win_w, rel[1:0], 2'd0);
		end else if (idx >= `SVPB_OFF_WIN_L && idx < `SVPB_OFF_FUNC) begin
			rel = idx - `SVPB_OFF_WIN_L;
			page_byte = field_byte(`SVPB_WIN_L, rel[1:0], 2'd0);
		end else if (idx == `SVPB_OFF_FUNC) begin
			page_byte = `SVPB_FUNC;
		end else if (idx == `SVPB_OFF_PHYS) begin
			page_byte = endo ? `SVPB_PHYS_HI_END : `SVPB_PHYS_HI_BASE;
		end else if (idx == `SVPB_OFF_PHYS + 7'd1) begin
			page_byte = `SVPB_PHYS_LO;
		end else if (idx >= `SVPB_OFF_BUF && idx < `SVPB_OFF_STD_CMD) begin
			rel = idx - `SVPB_OFF_BUF;
			page_byte = field_byte(`SVPB_BUF_SIZE, rel[1:0], 2'd0);
		end else if (idx >= `SVPB_OFF_STD_CMD && idx < `SVPB_OFF_VEND_CMD) begin
			rel = idx - `SVPB_OFF_STD_CMD;
			page_byte = field_byte(`SVPB_STD_CMD, rel[1:0], 2'd0);
		end else if (idx >= `SVPB_OFF_VEND_CMD && idx < `SVPB_OFF_VEND_PARM) begin
			rel = idx - `SVPB_OFF_VEND_CMD;
			// Only group C can be nonzero; D, E and F read zero.
			if (rel[2:1] == 2'd0) begin
				page_byte = field_byte({16'h0000, grp_c}, {1'b0, rel[0]}, 2'd2);
			end else begin
				page_byte = field_byte({16'h0000, `SVPB_VGRP_ZERO}, {1'b0, rel[0]}, 2'd2);
			end
		end else if (idx >= `SVPB_OFF_VEND_PARM && idx < `SVPB_OFF_IMG_CTL) begin
			rel = idx - `SVPB_OFF_VEND_PARM;
			if (rel[6:1] == 6'd0) begin
				page_byte = field_byte({16'h0000, `SVPB_VPARM_0X}, {1'b0, rel[0]}, 2'd2);
			end
		end else if (idx >= `SVPB_OFF_IMG_CTL && idx < `SVPB_OFF_IMG_PROC) begin
			rel = idx - `SVPB_OFF_IMG_CTL;
			if (rel < 7'd3) begin
				page_byte = `SVPB_IMG_CTL_STEP;
			end else if (rel > 7'd3) begin
				page_byte = `SVPB_IMG_CTL_DITHER;
			end
		end else if (idx >= `SVPB_OFF_IMG_PROC && idx < `SVPB_OFF_COMPR) begin
			rel = idx - `SVPB_OFF_IMG_PROC;
			page_byte = field_byte({16'h0000, proc}, {1'b0, rel[0]}, 2'd2);
		end else if (idx >= `SVPB_OFF_COMPR && idx < `SVPB_OFF_ENDORSE) begin
			rel = idx - `SVPB_OFF_COMPR;
			page_byte = field_byte({16'h0000, `SVPB_COMPR}, {1'b0, rel[0]}, 2'd2);
		end else if (idx >= `SVPB_OFF_ENDORSE && idx < `SVPB_OFF_ENDORSE + 7'd2) begin
			rel = idx - `SVPB_OFF_ENDORSE;
			page_byte = field_byte({16'h0000, endf}, {1'b0, rel[0]}, 2'd2);
		end
	endfunction

	//--------------------------------------------------------------------------
	// Sequencer
	//--------------------------------------------------------------------------

	svpb_state_t state_ff;
	logic [6:0]  idx_ff;
	logic        take;
	logic        accept;

	assign accept = inquiry_req && vital_data_enable && (page_code == `SVPB_PAGE_CODE);
	assign take   = byte_valid_ff && byte_ready;

	// A request that arrives while a page is going out is ignored, not queued.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= SVPB_IDLE;
		end else begin
			unique case (state_ff)
				SVPB_IDLE: begin
					if (accept) begin
						state_ff <= SVPB_SEND;
					end
				end
				SVPB_SEND: begin
					if (take && byte_last_ff) begin
						state_ff <= SVPB_DONE;
					end
				end
				SVPB_DONE: begin
					state_ff <= SVPB_IDLE;
				end
			endcase
		end
	end

	// Byte index walks 0..99; the next byte is staged as soon as one is taken.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			idx_ff <= 7'd0;
		end else if (state_ff == SVPB_IDLE) begin
			idx_ff <= 7'd0;
		end else if (take) begin
			idx_ff <= idx_ff + 7'd1;
		end
	end

	// Output byte stream, registered so outputs come straight from flip-flops.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			byte_valid_ff <= 1'b0;
			byte_data_ff  <= 8'h00;
			byte_last_ff  <= 1'b0;
		end else if (state_ff == SVPB_IDLE && accept) begin
			byte_valid_ff <= 1'b1;
			byte_data_ff  <= page_byte(7'd0, endorser_fitted, image_processing_option, model_wide);
			byte_last_ff  <= 1'b0;
		end else if (take) begin
			byte_valid_ff <= !byte_last_ff;
			byte_data_ff  <= byte_last_ff ? 8'h00 :
				page_byte(idx_ff + 7'd1, endorser_fitted, image_processing_option, model_wide);
			byte_last_ff  <= (idx_ff + 7'd1 == `SVPB_PAGE_BYTES - 7'd1);
		end
	end

	// Status flags: busy while a page is out, refused for a non-matching inquiry while idle.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			page_busy_ff    <= 1'b0;
			page_refused_ff <= 1'b0;
		end else begin
			page_busy_ff    <= (state_ff == SVPB_IDLE) ? accept :
				!(state_ff == SVPB_SEND && take && byte_last_ff) && state_ff == SVPB_SEND;
			page_refused_ff <= inquiry_req && !accept && state_ff == SVPB_IDLE;
		end
	end

	//--------------------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------------------

	page_start_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(state_ff == SVPB_IDLE && accept) |=> (byte_valid_ff && idx_ff == 7'd0
			&& byte_data_ff == `SVPB_DEV_TYPE))
		else $error("page did not start on accepted inquiry");
	no_start_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(state_ff == SVPB_IDLE && !accept) |=> !byte_valid_ff)
		else $error("page started without a valid inquiry");
	last_index_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		byte_last_ff |-> idx_ff == `SVPB_PAGE_BYTES - 7'd1)
		else $error("last byte not at index 99");
	len_byte_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(byte_valid_ff && idx_ff == `SVPB_OFF_LEN) |-> byte_data_ff == `SVPB_PAGE_LEN)
		else $error("page length byte wrong");
	min_res_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(byte_valid_ff && idx_ff == `SVPB_OFF_MIN_X + 7'd1)
			|-> byte_data_ff == (image_processing_option ? 8'h32 : 8'hC8))
		else $error("minimum resolution wrong");
	std_res_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(byte_valid_ff && idx_ff == `SVPB_OFF_STD_RES)
			|-> byte_data_ff == (image_processing_option ? 8'hFF : 8'h01))
		else $error("standard resolution high byte wrong");
	win_w_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(byte_valid_ff && idx_ff == `SVPB_OFF_WIN_W + 7'd2)
			|-> byte_data_ff == (model_wide ? 8'h09 : 8'h06))
		else $error("window width wrong");
	phys_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(byte_valid_ff && idx_ff == `SVPB_OFF_PHYS)
			|-> byte_data_ff == (endorser_fitted ? 8'h9A : 8'h92))
		else $error("physical function byte wrong");
	grp_c_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(byte_valid_ff && idx_ff == `SVPB_OFF_VEND_CMD + 7'd1)
			|-> byte_data_ff == (endorser_fitted ? 8'h02 : 8'h00))
		else $error("vendor group c low byte wrong");
	hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(byte_valid_ff && !byte_ready) |=> (byte_valid_ff && $stable(byte_data_ff)))
		else $error("byte changed while stalled");
	// Low bytes of both basic resolution fields carry 200 dpi.
	basic_res_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(byte_valid_ff && (idx_ff == `SVPB_OFF_BASIC_X + 7'd1
			|| idx_ff == `SVPB_OFF_BASIC_Y + 7'd1)) |-> byte_data_ff == 8'hC8)
		else $error("basic resolution wrong");
	// A nonzero step byte would tell the host that only fixed steps exist.
	res_step_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(byte_valid_ff && idx_ff == `SVPB_OFF_STEP) |-> byte_data_ff == 8'h00)
		else $error("resolution step wrong");
	// High bytes of both maximum resolution fields carry the 01h of 400 dpi.
	max_res_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(byte_valid_ff && (idx_ff == `SVPB_OFF_MAX_X || idx_ff == `SVPB_OFF_MAX_Y))
			|-> byte_data_ff == 8'h01)
		else $error("maximum resolution wrong");
	// Window length does not depend on any strap.
	win_len_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(byte_valid_ff && idx_ff == `SVPB_OFF_WIN_L + 7'd2) |-> byte_data_ff == 8'h0D)
		else $error("window length wrong");
	// The overflow bit must stay clear because no buffered data is ever lost.
	func_byte_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(byte_valid_ff && idx_ff == `SVPB_OFF_FUNC) |-> byte_data_ff == 8'h06)
		else $error("function byte wrong");
	// Second physical byte holds the converter bit count.
	phys_lo_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(byte_valid_ff && idx_ff == `SVPB_OFF_PHYS + 7'd1) |-> byte_data_ff == 8'h08)
		else $error("converter bit count wrong");
	// Buffer size second byte carries the 80h of eight megabytes.
	buf_size_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(byte_valid_ff && idx_ff == `SVPB_OFF_BUF + 7'd1) |-> byte_data_ff == 8'h80)
		else $error("buffer size wrong");
	// Third byte of the standard command bitmap.
	std_cmd_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(byte_valid_ff && idx_ff == `SVPB_OFF_STD_CMD + 7'd2) |-> byte_data_ff == 8'hED)
		else $error("standard command bitmap wrong");
	// Groups D, E and F hold no implemented command.
	vend_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(byte_valid_ff && idx_ff >= `SVPB_OFF_VEND_CMD + 7'd2
			&& idx_ff < `SVPB_OFF_VEND_PARM) |-> byte_data_ff == 8'h00)
		else $error("vendor groups d to f not zero");
	// Only the first vendor parameter group is supported.
	vparm_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(byte_valid_ff && idx_ff == `SVPB_OFF_VEND_PARM + 7'd1) |-> byte_data_ff == 8'h01)
		else $error("vendor parameter byte wrong");
	// Endorser byte follows the endorser strap.
	endorse_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(byte_valid_ff && idx_ff == `SVPB_OFF_ENDORSE)
			|-> byte_data_ff == (endorser_fitted ? 8'h81 : 8'h00))
		else $error("endorser byte wrong");
	// Barcode and reserved tail bytes read zero.
	tail_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(byte_valid_ff && idx_ff >= `SVPB_OFF_ENDORSE + 7'd2) |-> byte_data_ff == 8'h00)
		else $error("tail byte not zero");
	// Busy must cover every cycle in which a byte is offered.
	busy_cover_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		byte_valid_ff |-> page_busy_ff)
		else $error("byte offered while not busy");
	// A refused inquiry never starts a page.
	refuse_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		page_refused_ff |-> !byte_valid_ff)
		else $error("page sent for refused inquiry");

endmodule
`default_nettype wire

// ### testbench/svpb_host_model.sv
// Host adapter model that takes page bytes, promptly or with stalls.
`timescale 1ns/1ps
`default_nettype none

module svpb_host_model (
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	input  wire logic       slow,
	input  wire logic       clear,
	input  wire logic       byte_valid_ff,
	input  wire logic [7:0] byte_data_ff,
	input  wire logic       byte_last_ff,
	output var  logic       byte_ready
);
	logic [7:0] got_mem [0:127];
	int         got_cnt;
	int         last_at;

	// ------------------------------------------------------------------
	// Ready pacing
	// ------------------------------------------------------------------
	// Slow mode drops ready every other cycle, so each byte must stand until taken.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			byte_ready <= 1'b0;
		end else begin
			byte_ready <= slow ? ~byte_ready : 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Byte capture
	// ------------------------------------------------------------------
	// A byte counts only at an edge with valid and ready both high.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			got_cnt <= 0;
			last_at <= -1;
		end else if (clear) begin
			got_cnt <= 0;
			last_at <= -1;
		end else if (byte_valid_ff && byte_ready) begin
			if (got_cnt < 128) begin
				got_mem[got_cnt] <= byte_data_ff;
			end
			got_cnt <= got_cnt + 1;
			if (byte_last_ff) begin
				last_at <= got_cnt;
			end
		end
	end
endmodule
`default_nettype wire

// ### testbench/svpb_page_builder_test.sv
// Self-checking testbench of the vital product page builder.
`timescale 1ns/1ps
`default_nettype none

module svpb_page_builder_test;
	import svpb_pkg::*;

	logic       ref_clk;
	logic       rst_b;
	logic       inquiry_req;
	logic       vital_data_enable;
	logic [7:0] page_code;
	logic       endorser_fitted;
	logic       image_processing_option;
	logic       model_wide;
	logic       byte_ready;
	logic       byte_valid_ff;
	logic [7:0] byte_data_ff;
	logic       byte_last_ff;
	logic       page_busy_ff;
	logic       page_refused_ff;
	logic       slow;
	logic       clear;
	logic [7:0] exp_pg [0:99];
	int         mismatches;
	int         checked;

	// ------------------------------------------------------------------
	// Instances
	// ------------------------------------------------------------------
	svpb_page_builder u_svpb_page_builder (
		.ref_clk(ref_clk), .rst_b(rst_b), .inquiry_req(inquiry_req),
		.vital_data_enable(vital_data_enable), .page_code(page_code),
		.endorser_fitted(endorser_fitted), .image_processing_option(image_processing_option),
		.model_wide(model_wide), .byte_ready(byte_ready), .byte_valid_ff(byte_valid_ff),
		.byte_data_ff(byte_data_ff), .byte_last_ff(byte_last_ff),
		.page_busy_ff(page_busy_ff), .page_refused_ff(page_refused_ff));

	svpb_host_model u_svpb_host_model (
		.ref_clk(ref_clk), .rst_b(rst_b), .slow(slow), .clear(clear),
		.byte_valid_ff(byte_valid_ff), .byte_data_ff(byte_data_ff),
		.byte_last_ff(byte_last_ff), .byte_ready(byte_ready));

	// ------------------------------------------------------------------
	// Clock and helpers
	// ------------------------------------------------------------------
	// Half period of 2.5 ns gives the 200 MHz clock.
	always #2.5 ref_clk = ~ref_clk;

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Places a field of n bytes, most significant byte first.
	task automatic put(input int at, input logic [31:0] v, input int n);
		for (int k = 0; k < n; k++) begin
			exp_pg[at + k] = v[8 * (n - 1 - k) +: 8];
		end
	endtask

	// Expected page for one strap setting; unlisted bytes stay zero.
	task automatic make_exp(input logic e, input logic i, input logic w);
		exp_pg = '{default: 8'h00};
		put(0, 32'h06F05A00, 4);
		put(4, 32'h0000005F, 1);
		put(5, 32'h00C800C8, 4);
		put(10, 32'h01900190, 4);
		put(14, i ? 32'h00320032 : 32'h00C800C8, 4);
		put(18, i ? 32'h0000FFF0 : 32'h000001D0, 2);
		put(20, w ? 32'h00000980 : 32'h000006C0, 4);
		put(24, 32'h00000D80, 4);
		put(28, 32'h00000006, 1);
		put(32, e ? 32'h00009A08 : 32'h00009208, 2);
		put(34, 32'h00800000, 4);
		put(38, 32'h0000EDBF, 4);
		put(42, e ? 32'h00000002 : 32'h00000000, 2);
		put(50, 32'h00000001, 2);
		put(82, 32'hFFFFFF00, 4);
		put(86, 32'h00004848, 2);
		put(88, i ? 32'h0000FF40 : 32'h00008140, 2);
		put(90, 32'h0000E000, 2);
		put(92, e ? 32'h00008100 : 32'h00000000, 2);
	endtask

	// One-cycle inquiry; returns at the edge where the answer lands.
	task automatic send(input logic v, input logic [7:0] c);
		@(posedge ref_clk);
		inquiry_req <= 1'b1;
		vital_data_enable <= v;
		page_code <= c;
		@(posedge ref_clk);
		inquiry_req <= 1'b0;
	endtask

	// Full page read with straps and pacing from m, plus a stray inquiry mid-page.
	task automatic run_page(input logic [3:0] m);
		int n;
		make_exp(m[0], m[1], m[2]);
		@(posedge ref_clk);
		endorser_fitted <= m[0];
		image_processing_option <= m[1];
		model_wide <= m[2];
		slow <= m[3];
		clear <= 1'b1;
		@(posedge ref_clk);
		clear <= 1'b0;
		send(1'b1, 8'hF0);
		#1;
		check("first valid", byte_valid_ff, 1);
		check("first byte", byte_data_ff, 8'h06);
		check("busy during", page_busy_ff, 1);
		repeat (10) @(posedge ref_clk);
		send(1'b1, 8'hF0);
		#1;
		check("stray refused", page_refused_ff, 0);
		n = 0;
		while (u_svpb_host_model.got_cnt < 100 && n < 1000) begin
			@(posedge ref_clk);
			n++;
		end
		repeat (4) @(posedge ref_clk);
		#1;
		check("byte count", u_svpb_host_model.got_cnt, 100);
		check("last index", u_svpb_host_model.last_at, 99);
		check("busy after", page_busy_ff, 0);
		check("valid after", byte_valid_ff, 0);
		for (int k = 0; k < 100; k++) begin
			check("page byte", u_svpb_host_model.got_mem[k], exp_pg[k]);
		end
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		rst_b = 1'b0;
		inquiry_req = 1'b0;
		vital_data_enable = 1'b0;
		page_code = 8'h00;
		endorser_fitted = 1'b0;
		image_processing_option = 1'b0;
		model_wide = 1'b0;
		slow = 1'b0;
		clear = 1'b0;
		mismatches = 0;
		checked = 0;
		repeat (20) @(posedge ref_clk);
		check("reset valid", byte_valid_ff, 0);
		check("reset busy", page_busy_ff, 0);
		rst_b <= 1'b1;
		send(1'b0, 8'hF0);
		#1;
		check("refuse no enable", page_refused_ff, 1);
		check("refuse no data", byte_valid_ff, 0);
		send(1'b1, 8'hF1);
		#1;
		check("refuse bad code", page_refused_ff, 1);
		@(posedge ref_clk);
		#1;
		check("refuse pulse end", page_refused_ff, 0);
		check("refuse still idle", byte_valid_ff, 0);
		// Every strap combination, each with prompt and stalling pacing.
		for (int m = 0; m < 16; m++) begin
			run_page(m[3:0]);
		end
		test_done();
	end

	// Cuts a hang short; the full run needs well under 5000 cycles.
	initial begin
		#100000;
		mismatches++;
		test_done();
	end
endmodule
`default_nettype wire
